// File: src/jfa_consts.svh
// constants of the scan-driven fifo access block
`ifndef JFA_CONSTS_SVH
`define JFA_CONSTS_SVH
`define JFA_IR_W 3
`define JFA_IR_PUSH 3'h1
`define JFA_IR_POP 3'h2
`define JFA_IR_DRAIN 3'h3
`define JFA_DATA_W 8
`define JFA_FIFO_DEPTH 4
`define JFA_CLK_MHZ 50
`endif

// File: src/jfa_pkg.sv
// types and decode of the scan-driven fifo access block
`include "jfa_consts.svh"
package jfa_pkg;
  typedef enum logic [1:0] {JFA_OP_BYPASS, JFA_OP_PUSH, JFA_OP_POP, JFA_OP_DRAIN} jfa_op_t;
  function automatic jfa_op_t jfa_decode(input logic [`JFA_IR_W-1:0] ir);
    jfa_op_t op;
    op = JFA_OP_BYPASS;
    if (ir == `JFA_IR_PUSH) op = JFA_OP_PUSH;
    if (ir == `JFA_IR_POP) op = JFA_OP_POP;
    if (ir == `JFA_IR_DRAIN) op = JFA_OP_DRAIN;
    return op;
  endfunction
endpackage

// File: src/jfa_top.sv
// scan chain access to a byte fifo: push, pop and drain
// Behaviour
// - three-bit instruction selects push, pop, drain
// - push instruction writes exactly one fifo value per dr update
// - pop instruction reads at most one fifo value per dr capture, none when empty
// - drain reads back to back until empty
// - push chain shifts only on push and shift
// - one write pulse after update, stable data
// - pop selects read chain, one read pulse
// - read chain captures, then shifts toward tdo
// - drain request held until fifo empty
// - drain routes one-bit bypass tdi to tdo
// - both fifo ports run on 50 MHz clock
// - one scan instance, one shared decoder
// - tdi valid only while shift indication high; the bypass bit samples tdi on every tck rise
`timescale 1ns/1ns
`default_nettype none
`include "jfa_consts.svh"
module jfa_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] ONE = (AW+1)'(1);
  logic [W-1:0] mem [D];
  logic [AW:0] wptr, rptr, next_wptr, next_rptr;
  logic wr, rd;
  assign in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
  assign out_valid = (wptr != rptr);
  assign out_data = mem[rptr[AW-1:0]];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  always_comb begin
    next_wptr = wr ? wptr + ONE : wptr;
    next_rptr = rd ? rptr + ONE : rptr;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
endmodule

module jfa_top
  import jfa_pkg::*;
#(
  parameter int DW = `JFA_DATA_W,
  parameter int DEPTH = `JFA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // scan hub side, asynchronous to clk_sys
  input wire logic tck,
  input wire logic tdi,
  input wire logic [`JFA_IR_W-1:0] ir_in,
  input wire logic scan_capture_dr,
  input wire logic scan_shift_dr,
  input wire logic scan_update_dr,
  input wire logic scan_update_ir,
  output logic tdo,
  // drain stream
  input wire logic drain_ready,
  output logic drain_valid,
  output logic [DW-1:0] drain_data,
  // status
  output logic fifo_empty,
  output logic fifo_full,
  output logic drain_busy
);
  localparam int SW = `JFA_IR_W + 6;
  logic [SW-1:0] sync_a, sync_b;
  logic s_tck, s_tdi, s_cdr, s_sdr, s_udr, s_uir;
  logic [`JFA_IR_W-1:0] s_ir;
  logic [2:0] edge_q;
  logic tck_rise, udr_rise, uir_rise;
  jfa_op_t op;
  logic [DW-1:0] push_chain, next_push_chain, pop_chain, next_pop_chain;
  logic bypass, next_bypass, next_tdo;
  logic wr_pend, next_wr_pend, wr_fire;
  logic [DW-1:0] wr_data, next_wr_data;
  logic drain_req, next_drain_req;
  logic next_drain_valid;
  logic [DW-1:0] next_drain_data;
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [DW-1:0] f_out_data;
  logic pop_rd, drain_rd;

  // two-stage synchronisers, then edge detection on the second stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
      edge_q <= '0;
    end else begin
      sync_a <= {tck, tdi, scan_capture_dr, scan_shift_dr, scan_update_dr,
                 scan_update_ir, ir_in};
      sync_b <= sync_a;
      edge_q <= {s_tck, s_udr, s_uir};
    end
  end
  assign {s_tck, s_tdi, s_cdr, s_sdr, s_udr, s_uir, s_ir} = sync_b;
  assign tck_rise = s_tck && !edge_q[2];
  assign udr_rise = s_udr && !edge_q[1];
  assign uir_rise = s_uir && !edge_q[0];
  // single shared decoder serves write and read sides
  assign op = jfa_decode(s_ir);

  // scan chains and tdo select
  always_comb begin
    next_push_chain = push_chain;
    next_pop_chain = pop_chain;
    next_bypass = bypass;
    if (tck_rise) begin
      next_bypass = s_tdi;
      if (op == JFA_OP_PUSH && s_sdr) begin
        next_push_chain = {s_tdi, push_chain[DW-1:1]};
      end
      if (op == JFA_OP_POP && s_cdr) begin
        next_pop_chain = f_out_valid ? f_out_data : '0;
      end else if (op == JFA_OP_POP && s_sdr) begin
        next_pop_chain = {s_tdi, pop_chain[DW-1:1]};
      end
    end
    unique case (op)
      JFA_OP_PUSH: next_tdo = next_push_chain[0];
      JFA_OP_POP: next_tdo = next_pop_chain[0];
      JFA_OP_DRAIN: next_tdo = next_bypass;
      JFA_OP_BYPASS: next_tdo = next_bypass;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      push_chain <= '0;
      pop_chain <= '0;
      bypass <= 1'b0;
      tdo <= 1'b0;
    end else begin
      push_chain <= next_push_chain;
      pop_chain <= next_pop_chain;
      bypass <= next_bypass;
      tdo <= next_tdo;
    end
  end

  // write side: chain is latched at update and held until the fifo takes it
  assign wr_fire = wr_pend && f_in_ready;
  always_comb begin
    next_wr_pend = wr_pend && !f_in_ready;
    next_wr_data = wr_data;
    if (udr_rise && op == JFA_OP_PUSH) begin
      next_wr_pend = 1'b1;
      next_wr_data = push_chain;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_data <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_data <= next_wr_data;
    end
  end

  // read side: one read per capture on pop, bursts while draining
  assign pop_rd = tck_rise && op == JFA_OP_POP && s_cdr && f_out_valid;
  assign drain_rd = drain_req && f_out_valid && drain_ready && !pop_rd;
  assign f_out_ready = pop_rd || drain_rd;
  always_comb begin
    next_drain_req = drain_req && f_out_valid;
    if (uir_rise && op == JFA_OP_DRAIN) begin
      next_drain_req = 1'b1;
    end
    next_drain_valid = drain_rd;
    next_drain_data = drain_rd ? f_out_data : drain_data;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drain_req <= 1'b0;
      drain_valid <= 1'b0;
      drain_data <= '0;
    end else begin
      drain_req <= next_drain_req;
      drain_valid <= next_drain_valid;
      drain_data <= next_drain_data;
    end
  end
  assign drain_busy = drain_req;
  assign fifo_empty = !f_out_valid;
  assign fifo_full = !f_in_ready;

  // both fifo ports on the 50 MHz system clock
  jfa_fifo #(.W(DW), .D(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(wr_pend),
    .in_ready(f_in_ready),
    .in_data(wr_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_push_upd;
    udr_rise && op == JFA_OP_PUSH && f_in_ready && !wr_pend;
  endsequence
  sequence s_one_write;
    wr_fire ##1 !wr_fire;
  endsequence
  sequence s_pop_cap;
    tck_rise && op == JFA_OP_POP && s_cdr && f_out_valid;
  endsequence

  property p_decode;
    !(s_ir inside {`JFA_IR_PUSH, `JFA_IR_POP, `JFA_IR_DRAIN}) |-> op == JFA_OP_BYPASS;
  endproperty
  a_decode: assert property (p_decode) else $error("bad instruction decode");
  property p_decode_pop;
    s_ir == `JFA_IR_POP |-> op == JFA_OP_POP;
  endproperty
  a_decode_pop: assert property (p_decode_pop) else $error("pop not decoded");
  property p_push_write;
    s_push_upd |=> s_one_write;
  endproperty
  a_push_write: assert property (p_push_write) else $error("push did not write once");
  property p_write_data;
    wr_fire |-> wr_data == $past(push_chain, 1) || !$past(udr_rise);
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not chain");
  property p_push_hold;
    !(tck_rise && op == JFA_OP_PUSH && s_sdr) |=> $stable(push_chain);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("push chain moved");
  property p_pop_read;
    s_pop_cap |-> f_out_ready ##1 !pop_rd;
  endproperty
  a_pop_read: assert property (p_pop_read) else $error("pop read not single");
  property p_pop_capture;
    s_pop_cap |=> pop_chain == $past(f_out_data) ##[1:4] tdo == pop_chain[0];
  endproperty
  a_pop_capture: assert property (p_pop_capture) else $error("pop capture wrong");
  property p_drain_start;
    uir_rise && op == JFA_OP_DRAIN |=> drain_req;
  endproperty
  a_drain_start: assert property (p_drain_start) else $error("drain not started");
  property p_drain_burst;
    drain_req && f_out_valid && drain_ready && !pop_rd |-> f_out_ready ##1 drain_valid;
  endproperty
  a_drain_burst: assert property (p_drain_burst) else $error("drain read missing");
  property p_drain_bypass;
    $past(op) == JFA_OP_DRAIN |-> tdo == bypass;
  endproperty
  a_drain_bypass: assert property (p_drain_bypass) else $error("drain tdo not bypass");
  property p_drain_hold;
    drain_req && f_out_valid |=> drain_req;
  endproperty
  a_drain_hold: assert property (p_drain_hold) else $error("drain dropped early");
  property p_drain_stop;
    drain_req && !f_out_valid && !(uir_rise && op == JFA_OP_DRAIN) |=> !drain_req;
  endproperty
  a_drain_stop: assert property (p_drain_stop) else $error("drain held past empty");
  property p_push_shift;
    tck_rise && op == JFA_OP_PUSH && s_sdr |=>
      push_chain == $past({s_tdi, push_chain[DW-1:1]});
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push chain shift wrong");
  property p_no_read_idle;
    op != JFA_OP_POP && !drain_req |-> !f_out_ready;
  endproperty
  a_no_read_idle: assert property (p_no_read_idle) else $error("fifo read without request");
  property p_bypass_tdo;
    $past(op) == JFA_OP_BYPASS |-> tdo == bypass;
  endproperty
  a_bypass_tdo: assert property (p_bypass_tdo) else $error("idle tdo not bypass");
endmodule
`default_nettype wire

// File: sim/jfa_host.sv
// scan host model driving the hub-side indications
`timescale 1ns/1ns
`default_nettype none
module jfa_host (
  // scan hub side
  output logic tck,
  output logic tdi,
  output logic [2:0] ir_in,
  output logic cdr,
  output logic sdr,
  output logic udr,
  output logic uir,
  input wire logic tdo
);
  logic seen;
  initial begin
    {tck, tdi, ir_in, cdr, sdr, udr, uir} = '0;
  end
  // one 160 ns tck period, off the system clock phase; tdo taken just before the rise
  task automatic tick();
    #83 seen = tdo;
    tck = 1'b1;
    #77 tck = 1'b0;
  endtask
  task automatic ir(input logic [2:0] code);
    ir_in = code;
    uir = 1'b1;
    tick();
    uir = 1'b0;
  endtask
  task automatic dr(input logic [7:0] din, output logic [7:0] dout);
    cdr = 1'b1;
    tick();
    cdr = 1'b0;
    sdr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      tdi = din[i];
      tick();
      dout[i] = seen;
    end
    sdr = 1'b0;
    // released data line must not keep its last level
    tdi = ~tdi;
    udr = 1'b1;
    tick();
    udr = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_jfa_top.sv
// self-checking bench of the scan-driven fifo access block
`timescale 1ns/1ns
`default_nettype none
module tb_jfa_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic drain_ready = 1'b0;
  logic stall = 1'b1;
  logic tck, tdi, cdr, sdr, udr, uir, tdo, drain_valid, fifo_empty, fifo_full, drain_busy, b;
  logic [2:0] ir_in;
  logic [7:0] drain_data, got, v;
  logic [31:0] rnd;
  logic [7:0] model[$];
  logic [2:0] byp[6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int num_errors = 0;
  int comparisons = 0;
  int seed = 79863;
  always #10 clk_sys = ~clk_sys;
  jfa_top jfa_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck), .tdi(tdi), .ir_in(ir_in),
    .scan_capture_dr(cdr), .scan_shift_dr(sdr), .scan_update_dr(udr), .scan_update_ir(uir),
    .tdo(tdo), .drain_ready(drain_ready), .drain_valid(drain_valid), .drain_data(drain_data),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full), .drain_busy(drain_busy));
  jfa_host jfa_host_i (.tck(tck), .tdi(tdi), .ir_in(ir_in), .cdr(cdr), .sdr(sdr), .udr(udr),
    .uir(uir), .tdo(tdo));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // sink stalls at random unless held off
  always @(negedge clk_sys) begin
    rnd = $random(seed);
    drain_ready <= rnd[0] & ~stall;
  end
  // drain_valid stands one whole cycle; look at it mid-cycle
  always @(negedge clk_sys) begin
    if (drain_valid === 1'b1) begin
      check("drained byte", model.size() > 0 ? model.pop_front() : 8'h00, drain_data);
    end
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("reset outputs", 8'h01, 8'({fifo_full, drain_busy, drain_valid, tdo, fifo_empty}));
    foreach (byp[k]) begin
      jfa_host_i.ir(byp[k]);
      v = 8'($random(seed));
      b = tdi;
      jfa_host_i.dr(v, got);
      check("bypass chain", {v[6:0], b}, got);
    end
    check("bypass no write", 8'h01, 8'({fifo_full, fifo_empty}));
    $display("test bypass done");
    jfa_host_i.ir(3'h1);
    for (int i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      jfa_host_i.dr(v, got);
      model.push_back(v);
      repeat (4) @(negedge clk_sys);
      check("fill flags", i >= 3 ? 8'h02 : 8'h00, 8'({fifo_full, fifo_empty}));
    end
    $display("test push done");
    jfa_host_i.ir(3'h2);
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      jfa_host_i.dr(v, got);
      check("popped byte", model.pop_front(), got);
    end
    repeat (4) @(negedge clk_sys);
    check("pop level", 8'h00, 8'({fifo_full, fifo_empty}));
    $display("test pop done");
    jfa_host_i.ir(3'h3);
    repeat (4) @(negedge clk_sys);
    check("drain held", 8'h02, 8'({drain_busy, fifo_empty}));
    stall = 1'b0;
    for (int n = 0; n < 300 && !(fifo_empty === 1'b1 && drain_busy === 1'b0); n++) begin
      @(negedge clk_sys);
    end
    check("drain left", 8'h00, 8'(model.size()));
    check("drain end", 8'h01, 8'({drain_busy, fifo_empty}));
    $display("test drain done");
    jfa_host_i.ir(3'h2);
    jfa_host_i.dr(8'h5a, got);
    check("empty pop", 8'h00, got);
    $display("test empty pop done");
    end_sim();
  end
endmodule
`default_nettype wire
